// ===== design/saip_pkg.sv
// saip_pkg: constants and types of the serial audio port status block
// assumes a single 100 MHz clock domain shared with the serial core
package saip_pkg;

    // register page and offsets
    localparam logic [31:0] BASE_ADDR = 32'h8000_1000;
    localparam logic [11:0] OFF_TXD   = 12'h000;
    localparam logic [11:0] OFF_RXD   = 12'h008;
    localparam logic [11:0] OFF_CTRL  = 12'h010;
    localparam logic [11:0] OFF_FLAGS = 12'h014;
    localparam logic [11:0] OFF_MASK  = 12'h018;
    localparam logic [11:0] OFF_TCFG  = 12'h01c;
    localparam logic [11:0] OFF_RCFG  = 12'h020;
    localparam logic [11:0] OFF_TCLK  = 12'h024;
    localparam logic [11:0] OFF_QCS   = 12'h02c;
    localparam logic [11:0] OFF_TSLOT = 12'h048;
    localparam logic [11:0] OFF_RSLOT = 12'h04c;
    localparam logic [1:0]  SIZE_WORD = 2'h2;

    // control and configuration fields
    localparam int CTRL_MOD  = 0;
    localparam int CTRL_TX   = 1;
    localparam int CTRL_RX   = 2;
    localparam int CFG_QEN   = 0;
    localparam int MASK_RXG  = 12;
    localparam int MASK_TXG  = 13;
    localparam int QCS_TXWM  = 0;
    localparam int QCS_RXWM  = 4;
    localparam int QCS_TXCNT = 8;
    localparam int QCS_RXCNT = 12;

    // status flag positions
    localparam int F_RX_DONE = 0;
    localparam int F_TX_DONE = 1;
    localparam int F_RX_RDY  = 2;
    localparam int F_TX_EMPT = 3;
    localparam int F_RX_OVR  = 4;
    localparam int F_TX_UND  = 5;
    localparam int F_TX_FS   = 6;
    localparam int F_RX_FS   = 7;
    localparam int F_TX_LAST = 8;
    localparam int F_RX_LAST = 9;
    localparam int F_RX_LVL  = 10;
    localparam int F_TX_ROOM = 11;
    localparam int NSRC      = 12;

    localparam logic [11:0] W1C_M    = 12'h333;
    localparam logic [11:0] RX_SRC_M = 12'h695;
    localparam logic [11:0] TX_SRC_M = 12'h96a;
    localparam logic [11:0] RXQ_M    = 12'h400;
    localparam logic [11:0] TXQ_M    = 12'h800;
    localparam logic [11:0] RST_FLAGS = 12'h008;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // queues
    localparam int QDEPTH = 8;
    localparam int WORD_W = 24;
    localparam int CNT_W  = 4;

    typedef enum logic [3:0] {
        K_NONE, K_TXD, K_RXD, K_CTRL, K_FLAGS, K_MASK,
        K_TCFG, K_RCFG, K_TCLK, K_QCS, K_TSLOT, K_RSLOT
    } saip_kind_t;

    // slot and frame events from one shifter
    typedef struct packed {
        logic frame_start;
        logic next_slot;
        logic last_slot;
        logic frame_end;
    } saip_evt_t;

    typedef struct packed {
        logic [2:0]                     ctrl;
        logic [NSRC-1:0]                flags;
        logic [31:0]                    mask;
        logic [31:0]                    tcfg;
        logic [31:0]                    rcfg;
        logic [31:0]                    tclk;
        logic [7:0]                     wm;
        logic [31:0]                    tslot;
        logic [31:0]                    rslot;
        logic [QDEPTH-1:0][WORD_W-1:0]  rq;
        logic [2:0]                     rp;
        logic [CNT_W-1:0]               rcnt;
        logic [QDEPTH-1:0][WORD_W-1:0]  tq;
        logic [2:0]                     tp;
        logic [CNT_W-1:0]               tcnt;
        logic [WORD_W-1:0]              tx_last;
        logic [WORD_W-1:0]              tx_word;
        logic [31:0]                    rdata;
        logic                           ack;
        logic                           err;
        logic                           rx_run;
        logic                           tx_run;
        logic                           irq;
    } saip_state_t;

    function automatic saip_kind_t saip_decode(input logic [11:0] off);
        case (off)
            OFF_TXD:   saip_decode = K_TXD;
            OFF_RXD:   saip_decode = K_RXD;
            OFF_CTRL:  saip_decode = K_CTRL;
            OFF_FLAGS: saip_decode = K_FLAGS;
            OFF_MASK:  saip_decode = K_MASK;
            OFF_TCFG:  saip_decode = K_TCFG;
            OFF_RCFG:  saip_decode = K_RCFG;
            OFF_TCLK:  saip_decode = K_TCLK;
            OFF_QCS:   saip_decode = K_QCS;
            OFF_TSLOT: saip_decode = K_TSLOT;
            OFF_RSLOT: saip_decode = K_RSLOT;
            default:   saip_decode = K_NONE;
        endcase
    endfunction

endpackage

// ===== design/saip_status.sv
// saip_status: status flags, interrupt request and register decode
// assumes the serial core pulses its events one cycle each, synchronous
// Function
// - one interrupt output, OR of twelve flagged, maskable sources.
// - no request at all while the module enable bit is clear.
// - receive request needs receiver on, group enable, own enable; the level source also needs the queue.
// - transmit request needs transmitter on, group enable, own enable; the room source also needs the queue.
// - flags update when the next word's first bit has shifted.
// - frame-done, overrun, underrun, final-slot flags clear by writing one.
// - frame-start flags set on first slot, clear on next slot.
// - without queue, ready sets on word arrival, clears on data read.
// - without queue, overrun sets when a word arrives over unread data.
// - with queue, ready stays set while the receive queue holds words.
// - receive level flag set while fill is at or above watermark.
// - with queue, overrun sets on a push into a full queue.
// - without queue, empty sets when data moves out, clears on write.
// - without queue, underrun sets on a fetch with no fresh word.
// - with queue, empty stays clear while words remain, clears on write.
// - transmit room flag set while fill is at or below watermark.
// - with queue, underrun sets when the shifter finds the queue empty.
// - only full 32-bit register accesses are allowed.
// - error on read-only write, reserved offset, or beyond last register.
// - registers decode at the fixed base address of the page.
// - a disabled direction finishes its frame, then sets frame-done.
`timescale 1ns/10ps
module saip_status (
    // clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 ce_i,
    // register bus
    input  wire logic                 bus_sel_i,
    input  wire logic                 bus_wr_i,
    input  wire logic [1:0]           bus_size_i,
    input  wire logic [31:0]          bus_addr_i,
    input  wire logic [31:0]          bus_wdata_i,
    output logic      [31:0]          bus_rdata_o,
    output logic                      bus_ack_o,
    output logic                      bus_err_o,
    // serial core
    input  wire saip_pkg::saip_evt_t  rx_evt_i,
    input  wire saip_pkg::saip_evt_t  tx_evt_i,
    input  wire logic                 rx_word_i,
    input  wire logic [23:0]          rx_data_i,
    input  wire logic                 tx_fetch_i,
    output logic      [23:0]          tx_data_o,
    output logic                      rx_run_o,
    output logic                      tx_run_o,
    // interrupt
    output logic                      irq_o
);

    saip_pkg::saip_state_t s_q;
    saip_pkg::saip_state_t s_d;
    saip_pkg::saip_kind_t  kind;
    logic                  bad;
    logic                  rx_on;
    logic                  tx_on;
    logic                  rqen;
    logic                  tqen;
    logic                  rpop;
    logic                  rpush;
    logic                  tpush;
    logic                  tpop;
    logic [3:0]            rcap;
    logic [3:0]            tcap;
    logic [11:0]           active;

    always_comb begin
        s_d    = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        kind   = saip_pkg::saip_decode(bus_addr_i[11:0]);
        rx_on  = s_q.ctrl[saip_pkg::CTRL_MOD] & s_q.ctrl[saip_pkg::CTRL_RX];
        tx_on  = s_q.ctrl[saip_pkg::CTRL_MOD] & s_q.ctrl[saip_pkg::CTRL_TX];
        rqen   = s_q.rcfg[saip_pkg::CFG_QEN];
        tqen   = s_q.tcfg[saip_pkg::CFG_QEN];
        // without a queue the data register is a one-word queue
        rcap   = rqen ? 4'(saip_pkg::QDEPTH) : 4'h1;
        tcap   = tqen ? 4'(saip_pkg::QDEPTH) : 4'h1;
        rpop   = 1'b0;
        tpush  = 1'b0;
        rpush  = 1'b0;
        tpop   = 1'b0;
        active = 12'h000;
        bad    = (bus_addr_i[31:12] != saip_pkg::BASE_ADDR[31:12])
               | (bus_size_i != saip_pkg::SIZE_WORD)
               | (bus_addr_i[1:0] != 2'h0)
               | (kind == saip_pkg::K_NONE)
               | (bus_wr_i & (kind == saip_pkg::K_RXD));

        // register access, answered one cycle later
        if (bus_sel_i) begin
            s_d.ack = 1'b1;
            s_d.err = bad;
            s_d.rdata = saip_pkg::RST_WORD;
            if (!bad && !bus_wr_i) begin
                case (kind)
                    saip_pkg::K_TXD:   s_d.rdata = {8'h00, s_q.tx_last};
                    saip_pkg::K_RXD: begin
                        s_d.rdata = {8'h00, s_q.rq[s_q.rp]};
                        rpop = (s_q.rcnt != 4'h0);
                    end
                    saip_pkg::K_CTRL:  s_d.rdata = {29'h0, s_q.ctrl};
                    saip_pkg::K_FLAGS: s_d.rdata = {20'h0, s_q.flags};
                    saip_pkg::K_MASK:  s_d.rdata = s_q.mask;
                    saip_pkg::K_TCFG:  s_d.rdata = s_q.tcfg;
                    saip_pkg::K_RCFG:  s_d.rdata = s_q.rcfg;
                    saip_pkg::K_TCLK:  s_d.rdata = s_q.tclk;
                    saip_pkg::K_QCS:   s_d.rdata = {16'h0, s_q.rcnt,
                                                    s_q.tcnt, s_q.wm};
                    saip_pkg::K_TSLOT: s_d.rdata = s_q.tslot;
                    saip_pkg::K_RSLOT: s_d.rdata = s_q.rslot;
                    default:           s_d.rdata = saip_pkg::RST_WORD;
                endcase
            end
            if (!bad && bus_wr_i) begin
                case (kind)
                    saip_pkg::K_TXD: begin
                        s_d.tx_last = bus_wdata_i[23:0];
                        // a write into a full queue is dropped
                        tpush = (s_q.tcnt < tcap);
                    end
                    saip_pkg::K_CTRL:  s_d.ctrl = bus_wdata_i[2:0];
                    saip_pkg::K_FLAGS: s_d.flags = s_q.flags
                        & ~(bus_wdata_i[11:0] & saip_pkg::W1C_M);
                    saip_pkg::K_MASK:  s_d.mask = bus_wdata_i;
                    saip_pkg::K_TCFG:  s_d.tcfg = bus_wdata_i;
                    saip_pkg::K_RCFG:  s_d.rcfg = bus_wdata_i;
                    saip_pkg::K_TCLK:  s_d.tclk = bus_wdata_i;
                    saip_pkg::K_QCS:   s_d.wm = bus_wdata_i[7:0];
                    saip_pkg::K_TSLOT: s_d.tslot = bus_wdata_i;
                    saip_pkg::K_RSLOT: s_d.rslot = bus_wdata_i;
                    default:           s_d.wm = s_q.wm;
                endcase
            end
        end

        // receive word from the shifter, already past the next first bit
        if (rx_word_i && rx_on) begin
            if ((s_q.rcnt - 4'(rpop)) < rcap) begin
                rpush = 1'b1;
            end else begin
                s_d.flags[saip_pkg::F_RX_OVR] = 1'b1;
            end
        end
        if (rpush) begin
            s_d.rq[3'(s_q.rp + s_q.rcnt[2:0])] = rx_data_i;
        end
        s_d.rp   = s_q.rp + 3'(rpop);
        s_d.rcnt = s_q.rcnt - 4'(rpop) + 4'(rpush);

        // transmit fetch by the shifter
        if (tx_fetch_i && tx_on) begin
            if (s_q.tcnt != 4'h0) begin
                tpop = 1'b1;
                s_d.tx_word = s_q.tq[s_q.tp];
            end else begin
                s_d.flags[saip_pkg::F_TX_UND] = 1'b1;
            end
        end
        if (tpush) begin
            s_d.tq[3'(s_q.tp + s_q.tcnt[2:0])] = bus_wdata_i[23:0];
        end
        s_d.tp   = s_q.tp + 3'(tpop);
        s_d.tcnt = s_q.tcnt - 4'(tpop) + 4'(tpush);

        // slot events; a set in the clearing cycle wins
        if (rx_evt_i.next_slot) s_d.flags[saip_pkg::F_RX_FS] = 1'b0;
        if (tx_evt_i.next_slot) s_d.flags[saip_pkg::F_TX_FS] = 1'b0;
        if (rx_evt_i.frame_start) s_d.flags[saip_pkg::F_RX_FS] = 1'b1;
        if (tx_evt_i.frame_start) s_d.flags[saip_pkg::F_TX_FS] = 1'b1;
        if (rx_evt_i.last_slot) s_d.flags[saip_pkg::F_RX_LAST] = 1'b1;
        if (tx_evt_i.last_slot) s_d.flags[saip_pkg::F_TX_LAST] = 1'b1;
        // frame ends after the direction was switched off
        if (rx_evt_i.frame_end && !s_q.ctrl[saip_pkg::CTRL_RX])
            s_d.flags[saip_pkg::F_RX_DONE] = 1'b1;
        if (tx_evt_i.frame_end && !s_q.ctrl[saip_pkg::CTRL_TX])
            s_d.flags[saip_pkg::F_TX_DONE] = 1'b1;

        // level flags follow the queue contents
        s_d.flags[saip_pkg::F_RX_RDY]  = (s_d.rcnt != 4'h0);
        s_d.flags[saip_pkg::F_TX_EMPT] = (s_d.tcnt == 4'h0);
        s_d.flags[saip_pkg::F_RX_LVL]  = rqen
            & (s_d.rcnt >= s_q.wm[saip_pkg::QCS_RXWM +: 4]);
        s_d.flags[saip_pkg::F_TX_ROOM] = tqen
            & (s_d.tcnt <= s_q.wm[saip_pkg::QCS_TXWM +: 4]);

        // run outputs registered with the control bits
        s_d.rx_run = s_d.ctrl[saip_pkg::CTRL_MOD]
                   & s_d.ctrl[saip_pkg::CTRL_RX];
        s_d.tx_run = s_d.ctrl[saip_pkg::CTRL_MOD]
                   & s_d.ctrl[saip_pkg::CTRL_TX];

        // request gating
        active = s_d.flags & s_q.mask[11:0]
            & ((saip_pkg::RX_SRC_M
                & {12{rx_on & s_q.mask[saip_pkg::MASK_RXG]}})
             | (saip_pkg::TX_SRC_M
                & {12{tx_on & s_q.mask[saip_pkg::MASK_TXG]}}))
            & (~saip_pkg::RXQ_M | {12{rqen}})
            & (~saip_pkg::TXQ_M | {12{tqen}});
        s_d.irq = s_q.ctrl[saip_pkg::CTRL_MOD] & (|active);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q       <= '0;
            s_q.flags <= saip_pkg::RST_FLAGS;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign bus_rdata_o = s_q.rdata;
    assign bus_ack_o   = s_q.ack;
    assign bus_err_o   = s_q.err;
    assign tx_data_o   = s_q.tx_word;
    assign rx_run_o    = s_q.rx_run;
    assign tx_run_o    = s_q.tx_run;
    assign irq_o       = s_q.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_irq_module_off: assert property (
        ce_i && !s_q.ctrl[saip_pkg::CTRL_MOD] |=> !irq_o)
        else $error("request while module disabled");

    a_irq_level_set: assert property (
        ce_i && (|active) && s_q.ctrl[saip_pkg::CTRL_MOD] |=> irq_o)
        else $error("enabled flag gave no request");

    a_bus_size_err: assert property (
        ce_i && bus_sel_i && bus_size_i != saip_pkg::SIZE_WORD
        |=> bus_ack_o && bus_err_o)
        else $error("narrow access not refused");

    a_ro_write_err: assert property (
        ce_i && bus_sel_i && bus_wr_i
        && saip_pkg::saip_decode(bus_addr_i[11:0]) == saip_pkg::K_RXD
        |=> bus_err_o)
        else $error("write to read-only register accepted");

    a_w1c_overrun: assert property (
        ce_i && bus_sel_i && !bad && bus_wr_i && kind == saip_pkg::K_FLAGS
        && bus_wdata_i[saip_pkg::F_RX_OVR] && !rx_word_i
        |=> !s_q.flags[saip_pkg::F_RX_OVR])
        else $error("overrun flag not cleared by write");

    a_overrun_full: assert property (
        ce_i && rx_word_i && rx_on && !rpop && s_q.rcnt == rcap
        |=> s_q.flags[saip_pkg::F_RX_OVR] && $stable(s_q.rcnt))
        else $error("push into full queue not flagged");

    a_underrun_set: assert property (
        ce_i && tx_fetch_i && tx_on && s_q.tcnt == 4'h0
        |=> s_q.flags[saip_pkg::F_TX_UND])
        else $error("fetch from empty queue not flagged");

    a_fs_clear: assert property (
        ce_i && rx_evt_i.next_slot && !rx_evt_i.frame_start
        |=> !s_q.flags[saip_pkg::F_RX_FS])
        else $error("frame-start flag did not clear");

    a_empty_tracks: assert property (
        s_q.flags[saip_pkg::F_TX_EMPT] == (s_q.tcnt == 4'h0))
        else $error("empty flag disagrees with queue");

    a_ready_tracks: assert property (
        s_q.flags[saip_pkg::F_RX_RDY] == (s_q.rcnt != 4'h0))
        else $error("ready flag disagrees with queue");

    a_bus_answer: assert property (
        ce_i && bus_sel_i |=> bus_ack_o)
        else $error("access got no answer");

    a_fs_set: assert property (
        ce_i && tx_evt_i.frame_start |=> s_q.flags[saip_pkg::F_TX_FS])
        else $error("frame-start flag did not set");

    a_underrun_hold: assert property (
        ce_i && tx_fetch_i && tx_on && s_q.tcnt == 4'h0
        |=> $stable(tx_data_o))
        else $error("empty fetch changed transmit word");

endmodule // saip_status

// ===== sim/saip_core_model.sv
// saip_core_model: behavioural serial core facing the status block
// assumes each task is started just after a rising clock edge
`timescale 1ns/10ps
module saip_core_model (
    // clock
    input  wire logic           clk_i,
    // events and words toward the status block
    output saip_pkg::saip_evt_t rx_evt_o,
    output saip_pkg::saip_evt_t tx_evt_o,
    output logic                rx_word_o,
    output logic [23:0]         rx_data_o,
    output logic                tx_fetch_o
);
    initial begin
        rx_evt_o = '0;
        tx_evt_o = '0;
        rx_word_o = 1'b0;
        rx_data_o = 24'h5a5a5a;
        tx_fetch_o = 1'b0;
    end

    // one received word; data line shows junk outside the pulse
    task automatic word(input logic [23:0] d);
        rx_word_o = 1'b1;
        rx_data_o = d;
        @(posedge clk_i);
        #1;
        rx_word_o = 1'b0;
        rx_data_o = ~d;
    endtask

    // shifter takes one transmit word
    task automatic fetch();
        tx_fetch_o = 1'b1;
        @(posedge clk_i);
        #1;
        tx_fetch_o = 1'b0;
    endtask

    // one slot or frame event on either side
    task automatic evt(input logic tx, input saip_pkg::saip_evt_t e);
        if (tx)
            tx_evt_o = e;
        else
            rx_evt_o = e;
        @(posedge clk_i);
        #1;
        tx_evt_o = '0;
        rx_evt_o = '0;
    endtask
endmodule // saip_core_model

// ===== sim/tb_top.sv
// tb_top: self-checking bench for the serial audio status block
// assumes saip_pkg, saip_status and saip_core_model are compiled first
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic        w;
        logic [31:0] a;
        logic [31:0] d;
        logic [1:0]  s;
        logic        e;
        logic [31:0] r;
    } saip_row_t;

    logic                clk_i, sys_rst_i, ce_i, bus_sel_i, bus_wr_i;
    logic [1:0]          bus_size_i;
    logic [31:0]         bus_addr_i, bus_wdata_i, bus_rdata_o, rd;
    logic                bus_ack_o, bus_err_o, er;
    saip_pkg::saip_evt_t rx_evt_i, tx_evt_i;
    logic                rx_word_i, tx_fetch_i, rx_run_o, tx_run_o, irq_o;
    logic [23:0]         rx_data_i, tx_data_o;
    int                  n_mismatch = 0;
    int                  checked = 0;
    int                  cyc = 0;

    saip_row_t rows [19] = '{
        '{1'b0, 32'h80001014, 32'h0, 2'h2, 1'b0, 32'h8},
        '{1'b1, 32'h80001004, 32'h1, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h8000100c, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b1, 32'h80001028, 32'h1, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001030, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001044, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001050, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001058, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h8000105c, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b1, 32'h80001008, 32'h1, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001014, 32'h0, 2'h1, 1'b1, 32'h0},
        '{1'b0, 32'h80002014, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b0, 32'h80001016, 32'h0, 2'h2, 1'b1, 32'h0},
        '{1'b1, 32'h80001048, 32'ha5a5, 2'h2, 1'b0, 32'h0},
        '{1'b0, 32'h80001048, 32'h0, 2'h2, 1'b0, 32'ha5a5},
        '{1'b1, 32'h80001024, 32'h1234, 2'h2, 1'b0, 32'h0},
        '{1'b0, 32'h80001024, 32'h0, 2'h2, 1'b0, 32'h1234},
        '{1'b1, 32'h8000104c, 32'h5a, 2'h2, 1'b0, 32'h0},
        '{1'b0, 32'h8000104c, 32'h0, 2'h2, 1'b0, 32'h5a}
    };

    saip_status i_saip_status (
        .clk_i, .sys_rst_i, .ce_i, .bus_sel_i, .bus_wr_i, .bus_size_i,
        .bus_addr_i, .bus_wdata_i, .bus_rdata_o, .bus_ack_o, .bus_err_o,
        .rx_evt_i, .tx_evt_i, .rx_word_i, .rx_data_i, .tx_fetch_i,
        .tx_data_o, .rx_run_o, .tx_run_o, .irq_o
    );
    saip_core_model i_saip_core_model (
        .clk_i, .rx_evt_o(rx_evt_i), .tx_evt_o(tx_evt_i),
        .rx_word_o(rx_word_i), .rx_data_o(rx_data_i), .tx_fetch_o(tx_fetch_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, sn);
        checked++;
        if (sn !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask

    // one access; request lasts one cycle, a spare cycle follows
    task automatic bus(input logic w, input logic [31:0] a, d,
                       input logic [1:0] s);
        int n;
        n = 0;
        bus_sel_i = 1'b1;
        bus_wr_i = w;
        bus_addr_i = a;
        bus_wdata_i = d;
        bus_size_i = s;
        tick(1);
        bus_sel_i = 1'b0;
        while (bus_ack_o !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        chk("ack", 1'b1, bus_ack_o);
        rd = bus_rdata_o;
        er = bus_err_o;
        tick(1);
    endtask

    task automatic wreg(input logic [11:0] o, input logic [31:0] d);
        bus(1'b1, saip_pkg::BASE_ADDR + {20'h0, o}, d, 2'h2);
    endtask

    task automatic rreg(input logic [11:0] o);
        bus(1'b0, saip_pkg::BASE_ADDR + {20'h0, o}, 32'h0, 2'h2);
    endtask

    task automatic flag(input int b, input logic ex);
        rreg(12'h014);
        chk($sformatf("flag%0d", b), ex, rd[b]);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        bus_sel_i = 1'b0;
        bus_wr_i = 1'b0;
        bus_size_i = 2'h2;
        bus_addr_i = 32'h0;
        bus_wdata_i = 32'h0;
        tick(12);
        sys_rst_i = 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            chk("err", rows[i].e, er);
            if (!rows[i].w && !rows[i].e)
                chk("rdata", rows[i].r, rd);
        end
        $display("test register map done");
        wreg(12'h010, 32'h5);
        wreg(12'h018, 32'h1004);
        chk("rx_run", 1'b1, rx_run_o);
        i_saip_core_model.word(24'h123456);
        flag(2, 1'b1);
        chk("irq", 1'b1, irq_o);
        i_saip_core_model.word(24'h654321);
        flag(4, 1'b1);
        rreg(12'h008);
        chk("rxd", 32'h123456, rd);
        flag(2, 1'b0);
        chk("irq", 1'b0, irq_o);
        wreg(12'h014, 32'h0);
        flag(4, 1'b1);
        wreg(12'h014, 32'h10);
        flag(4, 1'b0);
        i_saip_core_model.word(24'h0000aa);
        wreg(12'h018, 32'h4);
        tick(2);
        chk("irq", 1'b0, irq_o);
        wreg(12'h018, 32'h1004);
        tick(2);
        chk("irq", 1'b1, irq_o);
        wreg(12'h010, 32'h4);
        tick(2);
        chk("irq", 1'b0, irq_o);
        chk("rx_run", 1'b0, rx_run_o);
        wreg(12'h010, 32'h5);
        rreg(12'h008);
        chk("rxd", 32'haa, rd);
        ce_i = 1'b0;
        i_saip_core_model.word(24'h000077);
        ce_i = 1'b1;
        flag(2, 1'b0);
        $display("test receive path done");
        wreg(12'h010, 32'h7);
        for (int t = 0; t < 2; t++) begin
            i_saip_core_model.evt(t[0], 4'h8);
            flag(7 - t, 1'b1);
            i_saip_core_model.evt(t[0], 4'h4);
            flag(7 - t, 1'b0);
            i_saip_core_model.evt(t[0], 4'h2);
            wreg(12'h014, 32'h0);
            flag(9 - t, 1'b1);
            wreg(12'h014, 32'h200 >> t);
            flag(9 - t, 1'b0);
        end
        wreg(12'h010, 32'h1);
        for (int t = 0; t < 2; t++) begin
            i_saip_core_model.evt(t[0], 4'h1);
            flag(t, 1'b1);
            wreg(12'h014, 32'h1 << t);
            flag(t, 1'b0);
        end
        $display("test frame events done");
        wreg(12'h010, 32'h3);
        chk("tx_run", 1'b1, tx_run_o);
        wreg(12'h018, 32'h2028);
        tick(2);
        chk("irq", 1'b1, irq_o);
        wreg(12'h000, 32'habcdef);
        flag(3, 1'b0);
        i_saip_core_model.fetch();
        flag(3, 1'b1);
        chk("txd", 24'habcdef, tx_data_o);
        i_saip_core_model.fetch();
        flag(5, 1'b1);
        chk("txd", 24'habcdef, tx_data_o);
        wreg(12'h014, 32'h20);
        $display("test transmit path done");
        wreg(12'h020, 32'h1);
        wreg(12'h02c, 32'h20);
        wreg(12'h010, 32'h5);
        for (int k = 0; k < 9; k++) begin
            i_saip_core_model.word(24'h100 + k[23:0]);
            flag(10, k >= 1);
        end
        flag(4, 1'b1);
        rreg(12'h02c);
        chk("qcs", 32'h8020, rd);
        for (int k = 0; k < 8; k++) begin
            flag(2, 1'b1);
            rreg(12'h008);
            chk("rxq", 32'h100 + k, rd);
            flag(10, k < 6);
        end
        flag(2, 1'b0);
        $display("test receive queue done");
        wreg(12'h01c, 32'h1);
        wreg(12'h02c, 32'h21);
        wreg(12'h010, 32'h3);
        wreg(12'h018, 32'h2800);
        tick(2);
        chk("irq", 1'b1, irq_o);
        wreg(12'h01c, 32'h0);
        tick(2);
        chk("irq", 1'b0, irq_o);
        wreg(12'h01c, 32'h1);
        wreg(12'h000, 32'h11);
        flag(3, 1'b0);
        wreg(12'h000, 32'h22);
        flag(11, 1'b0);
        i_saip_core_model.fetch();
        flag(11, 1'b1);
        flag(3, 1'b0);
        chk("txd", 24'h11, tx_data_o);
        i_saip_core_model.fetch();
        flag(3, 1'b1);
        i_saip_core_model.fetch();
        flag(5, 1'b1);
        chk("txd", 24'h22, tx_data_o);
        $display("test transmit queue done");
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        chk("irq", 1'b0, irq_o);
        rreg(12'h014);
        chk("flags", 32'h8, rd);
        rreg(12'h010);
        chk("ctrl", 32'h0, rd);
        $display("test reset done");
        results();
    end
endmodule // tb_top
